// *** acbsp_pkg.sv ***
/*
  Constants and state types for the cell-bus slave port.
  Assumes a 10 MHz core clock sampling both link clocks as plain inputs.
*/
package acbsp_pkg;
  localparam int unsigned ACBSP_BYTE_W = 8;
  localparam int unsigned ACBSP_ADDR_W = 5;
  localparam int unsigned ACBSP_CELL_LEN = 53;
  localparam logic [ACBSP_ADDR_W-1:0] ACBSP_NULL_ADDR = 5'h1F;
  localparam logic [ACBSP_ADDR_W-1:0] ACBSP_DEF_ADDR = 5'h01;
  localparam logic [ACBSP_BYTE_W-1:0] ACBSP_ZERO_BYTE = 8'h00;
  localparam logic [1:0] ACBSP_SYNC_IDLE = 2'h0;

  // Transmit side states, one-hot
  typedef enum logic [2:0] {
    ACBSP_TX_IDLE = 3'b001,
    ACBSP_TX_ARMED = 3'b010,
    ACBSP_TX_SEND = 3'b100
  } acbsp_tx_state_t;
endpackage

// *** acbsp_sync.sv ***
/*
  Two-flop synchroniser with level outputs only (no edge detect) for a link clock or pin bundle.
  Assumes the input is asynchronous to clock_in.
*/
`timescale 1ns/1ps
module acbsp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } acbsp_sync_state_t;

  acbsp_sync_state_t st_ff;
  acbsp_sync_state_t nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st.meta = async_in;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.sync;
endmodule

// *** acbsp_port.sv ***
/*
  Cell-bus slave port: byte-wide transmit and receive toward a bus master.
  Assumes the master makes both link clocks (much slower than clock_in);
  user side presents transmit bytes and takes received bytes one per pulse.
*/
`timescale 1ns/1ps
module acbsp_port
  import acbsp_pkg::*;
#(
  parameter int unsigned CELL_LEN = ACBSP_CELL_LEN
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic config_strap_pin_in,
  input wire logic [ACBSP_ADDR_W-1:0] own_addr_in,
  input wire logic tx_link_clock_in,
  input wire logic tx_enable_n_in,
  input wire logic [ACBSP_ADDR_W-1:0] tx_slave_select_in,
  input wire logic rx_link_clock_in,
  input wire logic rx_enable_n_in,
  input wire logic rx_cell_start_in,
  input wire logic [ACBSP_BYTE_W-1:0] rx_cell_byte_bus_in,
  input wire logic [ACBSP_ADDR_W-1:0] rx_slave_select_in,
  input wire logic user_tx_cell_ready_in,
  input wire logic [ACBSP_BYTE_W-1:0] user_tx_byte_in,
  input wire logic user_rx_space_in,
  output logic user_tx_take_out,
  output logic [ACBSP_BYTE_W-1:0] user_rx_byte_out,
  output logic user_rx_valid_out,
  output logic user_rx_first_out,
  output logic [ACBSP_BYTE_W-1:0] tx_cell_byte_bus_out,
  output logic tx_cell_byte_bus_oe_out,
  output logic tx_cell_start_out,
  output logic tx_cell_start_oe_out,
  output logic tx_cell_ready_flag_out,
  output logic tx_cell_ready_flag_oe_out,
  output logic rx_space_flag_out,
  output logic rx_space_flag_oe_out,
  output logic cell_port_select_out
);
  // Two link clocks, two enables and start, both addresses, receive byte
  localparam int unsigned SYNC_W = 5 + 2 * ACBSP_ADDR_W + ACBSP_BYTE_W;

  // Counter is eight bits wide; a cell needs at least two bytes
  if (CELL_LEN < 2 || CELL_LEN > 255) begin : g_bad_len
    $error("CELL_LEN out of range");
  end

  typedef struct packed {
    logic strap_done;
    logic sel;
    logic txc_d;
    logic rxc_d;
    acbsp_tx_state_t tx_st;
    logic [7:0] tx_cnt;
    logic [ACBSP_BYTE_W-1:0] tx_byte;
    logic tx_oe;
    logic tx_soc;
    logic tx_flag;
    logic tx_take;
    logic rx_pend;
    logic rx_space;
    logic rx_oe;
    logic [ACBSP_BYTE_W-1:0] rx_byte;
    logic rx_valid;
    logic rx_first;
  } acbsp_state_t;

  acbsp_state_t st_ff;
  acbsp_state_t nxt_st;
  logic [SYNC_W-1:0] s_in;
  logic [SYNC_W-1:0] s_q;
  logic txc_s, rxc_s, txen_n_s, rxen_n_s, rxsoc_s;
  logic [ACBSP_ADDR_W-1:0] txa_s, rxa_s;
  logic [ACBSP_BYTE_W-1:0] rxd_s;
  logic tx_rise, rx_rise, tx_hit, rx_hit;

  // All link pins pass two flops before use; strap, own address and user inputs do not
  assign s_in = {tx_link_clock_in, rx_link_clock_in, tx_enable_n_in, rx_enable_n_in,
                 rx_cell_start_in, tx_slave_select_in, rx_slave_select_in,
                 rx_cell_byte_bus_in};
  acbsp_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .async_in(s_in),
    .sync_out(s_q)
  );
  assign {txc_s, rxc_s, txen_n_s, rxen_n_s, rxsoc_s, txa_s, rxa_s, rxd_s} = s_q;

  // Address match decode, used on both directions
  function automatic logic addr_hit(input logic [ACBSP_ADDR_W-1:0] a,
                                    input logic [ACBSP_ADDR_W-1:0] own);
    addr_hit = (a == own) && (a != ACBSP_NULL_ADDR);
  endfunction

  assign tx_rise = txc_s && !st_ff.txc_d;
  assign rx_rise = rxc_s && !st_ff.rxc_d;
  assign tx_hit = st_ff.sel && addr_hit(txa_s, own_addr_in);
  assign rx_hit = st_ff.sel && addr_hit(rxa_s, own_addr_in);

  // Next-state logic for both directions
  always_comb begin
    nxt_st = st_ff;
    nxt_st.txc_d = txc_s;
    nxt_st.rxc_d = rxc_s;
    nxt_st.tx_take = 1'b0;
    nxt_st.rx_valid = 1'b0;
    nxt_st.rx_first = 1'b0;
    if (!st_ff.strap_done) begin
      nxt_st.strap_done = 1'b1;
      nxt_st.sel = config_strap_pin_in;
    end
    if (!st_ff.sel) begin
      // Port disabled: everything held quiet
      nxt_st.tx_st = ACBSP_TX_IDLE;
      nxt_st.tx_oe = 1'b0;
      nxt_st.rx_oe = 1'b0;
      nxt_st.tx_soc = 1'b0;
      nxt_st.tx_flag = 1'b0;
      nxt_st.rx_space = 1'b0;
      nxt_st.rx_pend = 1'b0;
    end else begin
      // Transmit side, updated on tx clock rises
      if (tx_rise) begin
        nxt_st.tx_oe = tx_hit;
        nxt_st.tx_flag = user_tx_cell_ready_in;
        nxt_st.tx_soc = 1'b0;
        case (st_ff.tx_st)
          ACBSP_TX_IDLE: begin
            if (tx_hit && user_tx_cell_ready_in) begin
              nxt_st.tx_st = ACBSP_TX_ARMED;
            end
          end
          ACBSP_TX_ARMED: begin
            if (!txen_n_s && tx_hit) begin
              // First byte and start marker next edge
              nxt_st.tx_byte = user_tx_byte_in;
              nxt_st.tx_soc = 1'b1;
              nxt_st.tx_take = 1'b1;
              nxt_st.tx_cnt = 8'h01;
              nxt_st.tx_st = ACBSP_TX_SEND;
            end
          end
          ACBSP_TX_SEND: begin
            if (!txen_n_s) begin
              nxt_st.tx_byte = user_tx_byte_in;
              nxt_st.tx_take = 1'b1;
              nxt_st.tx_cnt = st_ff.tx_cnt + 8'h01;
              if (st_ff.tx_cnt == 8'(CELL_LEN - 1)) begin
                nxt_st.tx_st = ACBSP_TX_IDLE;
              end
            end
          end
          default: nxt_st.tx_st = ACBSP_TX_IDLE;
        endcase
      end
      // Receive side, sampled on rx clock rises
      if (rx_rise) begin
        nxt_st.rx_oe = rx_hit;
        nxt_st.rx_space = user_rx_space_in;
        nxt_st.rx_pend = !rxen_n_s && rx_hit;
        if (st_ff.rx_pend && !rxen_n_s) begin
          // Enable seen last edge: take bus now
          nxt_st.rx_byte = rxd_s;
          nxt_st.rx_valid = 1'b1;
          nxt_st.rx_first = rxsoc_s;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_ff <= '{strap_done: 1'b0, sel: 1'b0, txc_d: 1'b0, rxc_d: 1'b0,
                 tx_st: ACBSP_TX_IDLE, tx_cnt: 8'h00, tx_byte: ACBSP_ZERO_BYTE,
                 tx_oe: 1'b0, tx_soc: 1'b0, tx_flag: 1'b0, tx_take: 1'b0,
                 rx_pend: 1'b0, rx_space: 1'b0, rx_oe: 1'b0,
                 rx_byte: ACBSP_ZERO_BYTE, rx_valid: 1'b0, rx_first: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state flops
  assign user_tx_take_out = st_ff.tx_take;
  assign user_rx_byte_out = st_ff.rx_byte;
  assign user_rx_valid_out = st_ff.rx_valid;
  assign user_rx_first_out = st_ff.rx_first;
  assign tx_cell_byte_bus_out = st_ff.tx_byte;
  assign tx_cell_byte_bus_oe_out = st_ff.tx_oe;
  assign tx_cell_start_out = st_ff.tx_soc;
  assign tx_cell_start_oe_out = st_ff.tx_oe;
  assign tx_cell_ready_flag_out = st_ff.tx_flag;
  assign tx_cell_ready_flag_oe_out = st_ff.tx_oe;
  assign rx_space_flag_out = st_ff.rx_space;
  assign rx_space_flag_oe_out = st_ff.rx_oe;
  assign cell_port_select_out = st_ff.sel;

  AST_OFF_QUIET: assert property (@(posedge clock_in) disable iff (reset_in)
    st_ff.strap_done && !st_ff.sel |-> !tx_cell_byte_bus_oe_out && !rx_space_flag_oe_out)
    else $error("outputs driven while port disabled");
  AST_SOC_ON_START: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(tx_cell_start_out) |-> st_ff.tx_st == ACBSP_TX_SEND && st_ff.tx_cnt == 8'h01)
    else $error("start marker not with first byte");
  AST_TX_AFTER_EN: assert property (@(posedge clock_in) disable iff (reset_in)
    st_ff.sel && tx_rise && st_ff.tx_st == ACBSP_TX_ARMED && !txen_n_s && tx_hit
    |=> tx_cell_start_out && user_tx_take_out)
    else $error("first byte late after enable");
  AST_TX_ONLY_EDGE: assert property (@(posedge clock_in) disable iff (reset_in)
    !tx_rise |=> $stable(tx_cell_byte_bus_out))
    else $error("tx bus changed off clock edge");
  AST_OE_ADDR: assert property (@(posedge clock_in) disable iff (reset_in)
    st_ff.sel && tx_rise |=> tx_cell_byte_bus_oe_out == $past(tx_hit))
    else $error("tx drive not tied to address");
  AST_RX_SELECTED: assert property (@(posedge clock_in) disable iff (reset_in)
    user_rx_valid_out |-> st_ff.sel && $past(st_ff.rx_pend))
    else $error("rx byte without selection");
  AST_SPACE: assert property (@(posedge clock_in) disable iff (reset_in)
    st_ff.sel && rx_rise |=> rx_space_flag_out == $past(user_rx_space_in))
    else $error("space flag wrong");
  AST_READY: assert property (@(posedge clock_in) disable iff (reset_in)
    st_ff.sel && tx_rise |=> tx_cell_ready_flag_out == $past(user_tx_cell_ready_in))
    else $error("cell ready flag wrong");
  AST_RX_EDGE: assert property (@(posedge clock_in) disable iff (reset_in)
    user_rx_valid_out |-> $past(rx_rise))
    else $error("rx byte off clock edge");

  COV_TX_CELL: cover property (@(posedge clock_in) $rose(tx_cell_start_out));
  COV_RX_FIRST: cover property (@(posedge clock_in) user_rx_first_out);
  COV_RX_BYTE: cover property (@(posedge clock_in) user_rx_valid_out && !user_rx_first_out);
endmodule

// *** acbsp_master_model.sv ***
/*
  Bus master model that faces the cell-bus slave port.
  Assumes the bench calls its tasks just after a falling edge of clock_in.
*/
`timescale 1ns/1ps
module acbsp_master_model (
  input wire logic clock_in,
  output logic tx_link_clock_out,
  output logic rx_link_clock_out,
  output logic tx_enable_n_out,
  output logic rx_enable_n_out,
  output logic rx_cell_start_out,
  output logic [7:0] rx_cell_byte_bus_out,
  output logic [4:0] tx_slave_select_out,
  output logic [4:0] rx_slave_select_out
);
  // Idle: clocks still, enables off, null address
  initial begin
    tx_link_clock_out = 1'b0;
    rx_link_clock_out = 1'b0;
    tx_enable_n_out = 1'b1;
    rx_enable_n_out = 1'b1;
    rx_cell_start_out = 1'b0;
    rx_cell_byte_bus_out = 8'hA5;
    tx_slave_select_out = 5'h1F;
    rx_slave_select_out = 5'h1F;
  end
  // One 800 ns link period; pins settle two core cycles before the rise
  task automatic tick(input bit rx);
    repeat (2) @(negedge clock_in);
    if (rx) rx_link_clock_out = 1'b1;
    else tx_link_clock_out = 1'b1;
    repeat (4) @(negedge clock_in);
    rx_link_clock_out = 1'b0;
    tx_link_clock_out = 1'b0;
    repeat (2) @(negedge clock_in);
  endtask
  // Transmit address and enable for the coming edge
  task automatic set_tx(input logic [4:0] a, input logic en_n);
    tx_slave_select_out = a;
    tx_enable_n_out = en_n;
  endtask
  // Enable one edge ahead, then one byte per edge, start with the first
  task automatic rx_cell(input logic [4:0] a, input logic [7:0] b[$]);
    rx_slave_select_out = a;
    rx_enable_n_out = 1'b0;
    tick(1'b1);
    foreach (b[k]) begin
      rx_cell_byte_bus_out = b[k];
      rx_cell_start_out = (k == 0);
      tick(1'b1);
    end
    rx_enable_n_out = 1'b1;
    rx_cell_start_out = 1'b0;
    // Released bus shows no stale byte
    rx_cell_byte_bus_out = ~rx_cell_byte_bus_out;
    tick(1'b1);
  endtask
endmodule

// *** tb.sv ***
/*
  Self-checking bench for the cell-bus slave port with a queue model.
  Assumes the master model drives every link pin of the port.
*/
`timescale 1ns/1ps
module tb;
  import acbsp_pkg::*;
  localparam int unsigned CL = 4;
  localparam logic [4:0] ME = 5'h05;
  logic clock_in, reset_in, strap, txrdy, rxspace, take, rxv, rxf, txs, txs_oe;
  logic rdy, rdy_oe, sp, sp_oe, sel, bus_oe, txc, rxc, txen, rxen, soc;
  logic [7:0] txb, rxb, bus, rxd, seed, txmem [CL];
  logic [4:0] txa, rxa;
  logic [8:0] rxq[$], expq[$];
  int tidx, mismatches, comparisons;
  acbsp_master_model m (.clock_in(clock_in), .tx_link_clock_out(txc),
    .rx_link_clock_out(rxc), .tx_enable_n_out(txen), .rx_enable_n_out(rxen),
    .rx_cell_start_out(soc), .rx_cell_byte_bus_out(rxd), .tx_slave_select_out(txa),
    .rx_slave_select_out(rxa));
  acbsp_port #(.CELL_LEN(CL)) dut (.clock_in(clock_in), .reset_in(reset_in),
    .config_strap_pin_in(strap), .own_addr_in(ME), .tx_link_clock_in(txc),
    .tx_enable_n_in(txen), .tx_slave_select_in(txa), .rx_link_clock_in(rxc),
    .rx_enable_n_in(rxen), .rx_cell_start_in(soc), .rx_cell_byte_bus_in(rxd),
    .rx_slave_select_in(rxa), .user_tx_cell_ready_in(txrdy), .user_tx_byte_in(txb),
    .user_rx_space_in(rxspace), .user_tx_take_out(take), .user_rx_byte_out(rxb),
    .user_rx_valid_out(rxv), .user_rx_first_out(rxf), .tx_cell_byte_bus_out(bus),
    .tx_cell_byte_bus_oe_out(bus_oe), .tx_cell_start_out(txs),
    .tx_cell_start_oe_out(txs_oe), .tx_cell_ready_flag_out(rdy),
    .tx_cell_ready_flag_oe_out(rdy_oe), .rx_space_flag_out(sp),
    .rx_space_flag_oe_out(sp_oe), .cell_port_select_out(sel));
  // 100 ns core clock
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Collect received bytes; present next transmit byte after each take
  always @(negedge clock_in) if (rxv === 1'b1) rxq.push_back({rxf, rxb});
  always @(negedge clock_in) begin
    if (take === 1'b1) begin
      tidx++;
      txb = txmem[tidx % CL];
    end
  end
  // Receive one cell of n random bytes at address a
  task automatic rx_run(input logic [4:0] a, input int n, input bit hit);
    logic [7:0] b[$];
    expq = {};
    rxq = {};
    for (int k = 0; k < n; k++) begin
      seed = lfsr(seed);
      b.push_back(seed);
      if (hit) expq.push_back({k == 0, seed});
    end
    m.rx_cell(a, b);
    chk8(8'(rxq.size()), 8'(expq.size()));
    foreach (expq[k]) begin
      chk8(rxq[k][7:0], expq[k][7:0]);
      chk1(rxq[k][8], expq[k][8]);
    end
    chk1(sp_oe, hit);
  endtask
  // Send one cell toward the master at address a
  task automatic tx_run(input logic [4:0] a, input bit hit);
    for (int k = 0; k < CL; k++) begin
      seed = lfsr(seed);
      txmem[k] = seed;
    end
    tidx = 0;
    txb = txmem[0];
    txrdy = 1'b1;
    m.set_tx(a, 1'b1);
    m.tick(1'b0);
    chk1(rdy, strap);
    chk1(rdy_oe, hit);
    m.set_tx(a, 1'b0);
    for (int k = 0; k < CL; k++) begin
      m.tick(1'b0);
      chk1(bus_oe, hit);
      chk1(txs_oe, hit);
      if (hit) chk8(bus, txmem[k]);
      if (hit) chk1(txs, k == 0);
    end
    txrdy = 1'b0;
    m.set_tx(5'h1F, 1'b1);
    m.tick(1'b0);
  endtask
  // Main sequence
  initial begin
    reset_in = 1'b1;
    strap = 1'b1;
    txrdy = 1'b0;
    rxspace = 1'b1;
    txb = 8'h00;
    seed = 8'h57;
    repeat (8) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk1(sel, 1'b1);
    rx_run(ME, 6, 1'b1);
    rxspace = 1'b0;
    m.tick(1'b1);
    chk1(sp, 1'b0);
    rxspace = 1'b1;
    m.tick(1'b1);
    chk1(sp, 1'b1);
    rx_run(ME ^ 5'h01, 3, 1'b0);
    tx_run(ME, 1'b1);
    tx_run(ME, 1'b1);
    tx_run(ME ^ 5'h02, 1'b0);
    strap = 1'b0;
    reset_in = 1'b1;
    repeat (8) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk1(sel, 1'b0);
    rx_run(ME, 3, 1'b0);
    chk1(sp, 1'b0);
    tx_run(ME, 1'b0);
    print_verdict;
  end
  // Watchdog well past the expected 37.2 us of traffic
  initial begin
    #2000000;
    mismatches++;
    print_verdict;
  end
endmodule
